// [hdl/tcsp_pkg.sv]
package tcsp_pkg;

    // ==========================================================
    // Address/command bytes
    localparam logic [7:0] CMD_GEN_RESET = 8'h01;
    localparam logic [7:0] CMD_CTRL_WR   = 8'h80;
    localparam logic [7:0] CMD_STAT_RD   = 8'h81;
    localparam logic [7:0] CMD_AUDIO_WR  = 8'h82;
    localparam logic [7:0] CMD_TXF_WR    = 8'h83;
    localparam logic [7:0] CMD_RXPROG_WR = 8'h84;
    localparam logic [7:0] CMD_CLONE_WR  = 8'h9c;

    // ==========================================================
    // Serial framing
    localparam logic [2:0] BIT_CNT_LAST  = 3'h7;
    localparam logic [1:0] BYTE_IDX_MAX  = 2'h3;

    // ==========================================================
    // Register fields and reset values
    localparam int         IRQ_MASK_BIT  = 0;
    localparam int         CLONE_EN_BIT  = 0;
    localparam logic [7:0] CTRL_WR_MASK  = 8'hfd;
    localparam logic [15:0] TXF_WR_MASK  = 16'h9fff;
    localparam int         SLOT_NUM      = 7;
    localparam int         SLOT_W        = 12;
    localparam int         SLOT_ADR_LSB  = 4;
    localparam logic [2:0] SLOT_UNUSED   = 3'h7;
    localparam logic [7:0] REG8_RST      = 8'h00;
    localparam logic [15:0] REG16_RST    = 16'h0000;
    localparam logic [11:0] SLOT_RST     = 12'h000;
    localparam logic [2:0] CODE_RST      = 3'h0;
    localparam logic [3:0] STAT_PAD      = 4'h0;

    // ==========================================================
    // Command decoder state
    typedef enum logic [2:0] {
        ST_CMD  = 3'b001,
        ST_DAT1 = 3'b010,
        ST_DAT2 = 3'b100
    } tcsp_state_t;

    function automatic logic cmd_has_data(input logic [7:0] cmd);
        return (cmd == CMD_CTRL_WR) || (cmd == CMD_AUDIO_WR) || (cmd == CMD_CLONE_WR)
            || (cmd == CMD_TXF_WR) || (cmd == CMD_RXPROG_WR);
    endfunction

    function automatic logic cmd_two_byte(input logic [7:0] cmd);
        return (cmd == CMD_TXF_WR) || (cmd == CMD_RXPROG_WR);
    endfunction

endpackage

// [hdl/tcsp_link_if.sv]
interface tcsp_link_if;
    logic [7:0] rx_byte;
    logic       rx_first;
    logic       rx_tog;
    logic [7:0] stat_word;

    modport lnk (
        output rx_byte,
        output rx_first,
        output rx_tog,
        input  stat_word
    );

    modport sys (
        input  rx_byte,
        input  rx_first,
        input  rx_tog,
        output stat_word
    );
endinterface

// [hdl/tcsp_link.sv]
module tcsp_link (
    input  wire logic  rst_i,
    input  wire logic  serial_clk_i,
    input  wire logic  chip_select_n_i,
    input  wire logic  cmd_data_i,
    output logic       reply_data_o,
    output logic       reply_data_oe_n_o,
    tcsp_link_if.lnk   lif
);

    logic [6:0] shift_r;
    logic [2:0] bit_cnt_r;
    logic [1:0] byte_idx_r;
    logic [7:0] tx_shift_r;
    logic       tx_act_r;
    logic [7:0] rx_byte_r;
    logic       rx_first_r;
    logic       rx_tog_r;

    wire        byte_end_w = (bit_cnt_r == tcsp_pkg::BIT_CNT_LAST);
    wire [7:0]  byte_w     = {shift_r, cmd_data_i};
    wire        stat_rd_w  = byte_end_w && (byte_idx_r == 2'h0)
                             && (byte_w == tcsp_pkg::CMD_STAT_RD);

    // ==========================================================
    // Receive on the rising edge; deselect discards a partial byte
    always_ff @(posedge serial_clk_i or posedge chip_select_n_i) begin
        if (chip_select_n_i) begin
            shift_r    <= 7'h00;
            bit_cnt_r  <= 3'h0;
            byte_idx_r <= 2'h0;
        end else begin
            shift_r    <= byte_w[6:0];
            bit_cnt_r  <= bit_cnt_r + 3'h1;
            if (byte_end_w && byte_idx_r != tcsp_pkg::BYTE_IDX_MAX) begin
                byte_idx_r <= byte_idx_r + 2'h1;
            end
        end
    end

    // Toggle must survive deselect, so only the system reset clears it
    always_ff @(posedge serial_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_byte_r  <= 8'h00;
            rx_first_r <= 1'b0;
            rx_tog_r   <= 1'b0;
        end else if (!chip_select_n_i && byte_end_w) begin
            rx_byte_r  <= byte_w;
            rx_first_r <= (byte_idx_r == 2'h0);
            rx_tog_r   <= ~rx_tog_r;
        end
    end

    // ==========================================================
    // Reply shifter: status word is frozen by the system side while selected
    always_ff @(posedge serial_clk_i or posedge chip_select_n_i) begin
        if (chip_select_n_i) begin
            tx_shift_r <= 8'h00;
            tx_act_r   <= 1'b0;
        end else if (byte_end_w) begin
            tx_shift_r <= lif.stat_word;
            tx_act_r   <= stat_rd_w;
        end else begin
            tx_shift_r <= {tx_shift_r[6:0], 1'b0};
        end
    end

    always_ff @(negedge serial_clk_i or posedge chip_select_n_i) begin
        if (chip_select_n_i) begin
            reply_data_o      <= 1'b0;
            reply_data_oe_n_o <= 1'b1;
        end else begin
            reply_data_o      <= tx_shift_r[7];
            reply_data_oe_n_o <= ~tx_act_r;
        end
    end

    assign lif.rx_byte  = rx_byte_r;
    assign lif.rx_first = rx_first_r;
    assign lif.rx_tog   = rx_tog_r;

    // ==========================================================
    // Checks
    property p_byte_msb_first;
        @(posedge serial_clk_i) disable iff (chip_select_n_i || rst_i)
        byte_end_w |=> rx_byte_r == {$past(shift_r), $past(cmd_data_i)};
    endproperty
    a_byte_msb_first: assert property (p_byte_msb_first)
        else $error("received byte not assembled msb first");

    // Reply may only drive during the byte right after the command byte
    property p_reply_only_on_read;
        @(posedge serial_clk_i) disable iff (chip_select_n_i || rst_i)
        !reply_data_oe_n_o |-> byte_idx_r == 2'h1;
    endproperty
    a_reply_only_on_read: assert property (p_reply_only_on_read)
        else $error("reply output driven outside a reply byte");

endmodule // tcsp_link

// [hdl/tcsp_top.sv]
// Behaviour
// - Command bytes are eight bits, sent msb first, clocked by the serial clock.
// - Reply bits shift out with the serial clock only while selected.
// - Reply output is released whenever no reply byte is being sent.
// - Chip select frames every transfer; early deselect aborts it.
// - A pending, enabled interrupt pulls the interrupt line to zero.
// - Interrupt line is open drain: pulls low or floats.
// - Interrupt is driven only when mask bit 0 of control allows it.
// - Each transaction opens with one address/command byte.
// - Write commands carry one or two data bytes after the command.
// - Read commands return exactly one reply byte.
// - Up to seven tone slots are programmed through the port.
// - Reading tone status clears the pending interrupt.
// - Sixteen-bit registers take the upper byte first.
// - General reset has no data and zeroes registers except tone code.
// - Mask one enables the interrupt, mask zero suppresses it.
module tcsp_top (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         serial_clk_i,
    input  wire logic         chip_select_n_i,
    input  wire logic         cmd_data_i,
    input  wire logic         tone_detect_i,
    input  wire logic [2:0]   tone_code_i,
    output logic              reply_data_o,
    output logic              reply_data_oe_n_o,
    output logic              interrupt_request_n_o,
    output logic              interrupt_request_oe_n_o,
    output logic [7:0]        ctrl_o,
    output logic [7:0]        audio_o,
    output logic [15:0]       tx_freq_o,
    output logic              clone_en_o,
    output logic [83:0]       rx_slots_o
);

    tcsp_link_if lif ();

    // ==========================================================
    // Serial-clock side
    tcsp_link u_link (
        .rst_i             (rst_i),
        .serial_clk_i      (serial_clk_i),
        .chip_select_n_i   (chip_select_n_i),
        .cmd_data_i        (cmd_data_i),
        .reply_data_o      (reply_data_o),
        .reply_data_oe_n_o (reply_data_oe_n_o),
        .lif               (lif)
    );

    // ==========================================================
    // Crossing into the system clock
    logic tog_s1_r;
    logic tog_s2_r;
    logic tog_s3_r;
    logic cs_s1_r;
    logic cs_s2_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tog_s1_r <= 1'b0;
            tog_s2_r <= 1'b0;
            tog_s3_r <= 1'b0;
            cs_s1_r  <= 1'b1;
            cs_s2_r  <= 1'b1;
        end else begin
            tog_s1_r <= lif.rx_tog;
            tog_s2_r <= tog_s1_r;
            tog_s3_r <= tog_s2_r;
            cs_s1_r  <= chip_select_n_i;
            cs_s2_r  <= cs_s1_r;
        end
    end

    // Byte stays still for seven more serial edges, far longer than the sync delay
    wire       take_w  = tog_s2_r ^ tog_s3_r;
    wire [7:0] byte_w  = lif.rx_byte;
    wire       first_w = take_w && lif.rx_first;
    wire       data_w  = take_w && !lif.rx_first;
    wire       abort_w = cs_s2_r;

    // ==========================================================
    // Command decoding
    tcsp_pkg::tcsp_state_t state_r;
    tcsp_pkg::tcsp_state_t state_nxt;
    logic [7:0]            cmd_r;
    logic [7:0]            hi_r;

    wire greset_w   = first_w && (byte_w == tcsp_pkg::CMD_GEN_RESET);
    wire stat_rd_w  = first_w && (byte_w == tcsp_pkg::CMD_STAT_RD);
    wire two_w      = tcsp_pkg::cmd_two_byte(cmd_r);
    wire commit8_w  = data_w && (state_r == tcsp_pkg::ST_DAT1) && !two_w;
    wire hi_take_w  = data_w && (state_r == tcsp_pkg::ST_DAT1) && two_w;
    wire commit16_w = data_w && (state_r == tcsp_pkg::ST_DAT2);
    wire [15:0] word_w = {hi_r, byte_w};
    wire [2:0]  slot_adr_w = hi_r[tcsp_pkg::SLOT_ADR_LSB +: 3];
    wire        slot_we_w  = commit16_w && (cmd_r == tcsp_pkg::CMD_RXPROG_WR)
                             && (slot_adr_w != tcsp_pkg::SLOT_UNUSED);

    always_comb begin
        state_nxt = state_r;
        if (first_w) begin
            state_nxt = tcsp_pkg::cmd_has_data(byte_w) ? tcsp_pkg::ST_DAT1
                                                       : tcsp_pkg::ST_CMD;
        end else if (data_w) begin
            unique case (state_r)
                tcsp_pkg::ST_DAT1: begin
                    state_nxt = two_w ? tcsp_pkg::ST_DAT2 : tcsp_pkg::ST_CMD;
                end
                tcsp_pkg::ST_DAT2: begin
                    state_nxt = tcsp_pkg::ST_CMD;
                end
                tcsp_pkg::ST_CMD: begin
                    state_nxt = tcsp_pkg::ST_CMD;
                end
                default: begin
                    state_nxt = tcsp_pkg::ST_CMD;
                end
            endcase
        end else if (abort_w) begin
            state_nxt = tcsp_pkg::ST_CMD;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= tcsp_pkg::ST_CMD;
            cmd_r   <= tcsp_pkg::REG8_RST;
            hi_r    <= tcsp_pkg::REG8_RST;
        end else begin
            state_r <= state_nxt;
            if (first_w) begin
                cmd_r <= byte_w;
            end
            if (hi_take_w) begin
                hi_r <= byte_w;
            end
        end
    end

    // ==========================================================
    // Write registers
    logic [7:0]                  ctrl_r;
    logic [7:0]                  audio_r;
    logic [15:0]                 txf_r;
    logic                        clone_r;
    logic [tcsp_pkg::SLOT_W-1:0] slot_r [tcsp_pkg::SLOT_NUM];

    always_ff @(posedge clk_i) begin
        if (rst_i || greset_w) begin
            ctrl_r  <= tcsp_pkg::REG8_RST;
            audio_r <= tcsp_pkg::REG8_RST;
            txf_r   <= tcsp_pkg::REG16_RST;
            clone_r <= 1'b0;
        end else begin
            if (commit8_w && cmd_r == tcsp_pkg::CMD_CTRL_WR) begin
                ctrl_r <= byte_w & tcsp_pkg::CTRL_WR_MASK;
            end
            if (commit8_w && cmd_r == tcsp_pkg::CMD_AUDIO_WR) begin
                audio_r <= byte_w;
            end
            if (commit8_w && cmd_r == tcsp_pkg::CMD_CLONE_WR) begin
                clone_r <= byte_w[tcsp_pkg::CLONE_EN_BIT];
            end
            if (commit16_w && cmd_r == tcsp_pkg::CMD_TXF_WR) begin
                txf_r <= word_w & tcsp_pkg::TXF_WR_MASK;
            end
        end
    end

    // Slot seven is never written, so a stray address cannot alias a real slot
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < tcsp_pkg::SLOT_NUM; i++) begin
            if (rst_i || greset_w) begin
                slot_r[i] <= tcsp_pkg::SLOT_RST;
            end else if (slot_we_w && slot_adr_w == 3'(i)) begin
                slot_r[i] <= word_w[tcsp_pkg::SLOT_W-1:0];
            end
        end
    end

    // ==========================================================
    // Tone status and interrupt
    logic       det_r;
    logic [2:0] code_r;
    logic       pend_r;
    logic       pend_nxt;
    logic [7:0] stat_word_r;

    wire det_event_w = tone_detect_i ^ det_r;
    wire det_rise_w  = tone_detect_i && !det_r;
    wire irq_on_w    = pend_r && ctrl_r[tcsp_pkg::IRQ_MASK_BIT];

    // A detect change in the clearing cycle keeps the interrupt pending
    always_comb begin
        pend_nxt = pend_r;
        if (stat_rd_w || greset_w) begin
            pend_nxt = 1'b0;
        end
        if (det_event_w) begin
            pend_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            det_r  <= 1'b0;
            code_r <= tcsp_pkg::CODE_RST;
            pend_r <= 1'b0;
        end else begin
            det_r  <= greset_w ? 1'b0 : tone_detect_i;
            pend_r <= pend_nxt;
            if (det_rise_w) begin
                code_r <= tone_code_i;
            end
        end
    end

    // Reply word only moves while deselected, so the serial side reads it as static
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_word_r <= tcsp_pkg::REG8_RST;
        end else if (abort_w) begin
            stat_word_r <= {tcsp_pkg::STAT_PAD, det_r, code_r};
        end
    end

    assign lif.stat_word = stat_word_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            interrupt_request_n_o    <= 1'b0;
            interrupt_request_oe_n_o <= 1'b1;
        end else begin
            interrupt_request_n_o    <= 1'b0;
            interrupt_request_oe_n_o <= ~irq_on_w;
        end
    end

    // ==========================================================
    // Outputs
    assign ctrl_o     = ctrl_r;
    assign audio_o    = audio_r;
    assign tx_freq_o  = txf_r;
    assign clone_en_o = clone_r;

    for (genvar g = 0; g < tcsp_pkg::SLOT_NUM; g++) begin : g_slot
        assign rx_slots_o[g*tcsp_pkg::SLOT_W +: tcsp_pkg::SLOT_W] = slot_r[g];
    end

    // ==========================================================
    // Checks
    property p_irq_masked;
        @(posedge clk_i) disable iff (rst_i)
        !ctrl_r[tcsp_pkg::IRQ_MASK_BIT] |=> interrupt_request_oe_n_o;
    endproperty
    a_irq_masked: assert property (p_irq_masked)
        else $error("interrupt driven while masked");

    property p_irq_enabled;
        @(posedge clk_i) disable iff (rst_i)
        (pend_r && ctrl_r[tcsp_pkg::IRQ_MASK_BIT]) |=> !interrupt_request_oe_n_o;
    endproperty
    a_irq_enabled: assert property (p_irq_enabled)
        else $error("enabled pending interrupt not driven");

    property p_irq_level;
        @(posedge clk_i) disable iff (rst_i)
        !interrupt_request_oe_n_o |-> interrupt_request_n_o == 1'b0;
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt line driven high");

    property p_read_clears;
        @(posedge clk_i) disable iff (rst_i)
        (stat_rd_w && !det_event_w) |=> !pend_r ##1 interrupt_request_oe_n_o;
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("status read did not release interrupt");

    property p_event_wins;
        @(posedge clk_i) disable iff (rst_i)
        det_event_w |=> pend_r;
    endproperty
    a_event_wins: assert property (p_event_wins)
        else $error("tone event lost");

    property p_gen_reset;
        @(posedge clk_i) disable iff (rst_i)
        (greset_w && !det_rise_w) |=> ctrl_r == 8'h00 && txf_r == 16'h0000
            && !clone_r && code_r == $past(code_r);
    endproperty
    a_gen_reset: assert property (p_gen_reset)
        else $error("general reset result wrong");

    property p_txf_hi_first;
        @(posedge clk_i) disable iff (rst_i)
        (commit16_w && cmd_r == tcsp_pkg::CMD_TXF_WR)
            |=> txf_r == ({$past(hi_r), $past(byte_w)} & tcsp_pkg::TXF_WR_MASK);
    endproperty
    a_txf_hi_first: assert property (p_txf_hi_first)
        else $error("sixteen-bit write byte order wrong");

    property p_abort;
        @(posedge clk_i) disable iff (rst_i)
        (abort_w && !take_w) |=> state_r == tcsp_pkg::ST_CMD;
    endproperty
    a_abort: assert property (p_abort)
        else $error("deselect did not abort transaction");

    property p_cmd_data;
        @(posedge clk_i) disable iff (rst_i)
        (first_w && tcsp_pkg::cmd_has_data(byte_w)) |=> state_r == tcsp_pkg::ST_DAT1;
    endproperty
    a_cmd_data: assert property (p_cmd_data)
        else $error("write command did not await data");

    cover property (@(posedge clk_i) disable iff (rst_i) stat_rd_w && pend_r);
    cover property (@(posedge clk_i) disable iff (rst_i) slot_we_w);
    cover property (@(posedge clk_i) disable iff (rst_i) greset_w);
    cover property (@(posedge clk_i) disable iff (rst_i)
        data_w && state_r == tcsp_pkg::ST_DAT2 && abort_w);

endmodule // tcsp_top

// [verification/tcsp_host_model.sv]
module tcsp_host_model (
    output logic      serial_clk_o,
    output logic      chip_select_n_o,
    output logic      cmd_data_o,
    input  wire logic reply_data_i,
    input  wire logic reply_data_oe_n_i
);
    timeunit 1ns;
    timeprecision 100ps;

    // ==========================================================
    // Reply line as the host sees it
    logic held_r = 1'b0;
    // No pull on the reply pin: a released line must not look like the last bit
    wire  reply_line = reply_data_oe_n_i ? ~held_r : reply_data_i;

    initial begin
        serial_clk_o = 1'b0;
        chip_select_n_o = 1'b1;
        cmd_data_o = 1'b0;
    end

    always @(posedge serial_clk_o) begin
        if (!reply_data_oe_n_i) held_r <= reply_data_i;
    end

    // ==========================================================
    // One framed transfer; the clock stands still outside frames
    task automatic xfer(input logic [23:0] tx, input int nbits, output logic [7:0] rx);
        chip_select_n_o = 1'b0;
        rx = 8'h00;
        #3;
        for (int i = 0; i < nbits; i++) begin
            cmd_data_o = tx[23 - i];
            #3;
            serial_clk_o = 1'b1;
            if (i >= 8 && i < 16) rx = {rx[6:0], reply_line};
            #3;
            serial_clk_o = 1'b0;
        end
        cmd_data_o = ~cmd_data_o;
        #3;
        chip_select_n_o = 1'b1;
        #20;
    endtask
endmodule // tcsp_host_model

// [verification/tone_codec_host_serial_port_bench.sv]
module tone_codec_host_serial_port_bench;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [116:0] ALL_RST = {tcsp_pkg::REG8_RST, tcsp_pkg::REG8_RST,
        tcsp_pkg::REG16_RST, 1'b0, {7{tcsp_pkg::SLOT_RST}}};

    logic        clk_i;
    logic        rst_i;
    logic        tone_detect_i;
    logic [2:0]  tone_code_i;
    wire         sclk, chip_select_n, cdat, rdat, rdat_oe_n, irq_n, irq_oe_n, clone;
    wire  [7:0]  ctrl, audio;
    wire  [15:0] txf;
    wire  [83:0] slots;
    // External pull-up on the shared interrupt line
    wire         irq_line = irq_oe_n ? 1'b1 : irq_n;
    int          n_errors;
    int          checks_done;
    logic [7:0]  rx;
    logic [83:0] exp_s;

    tcsp_top dut (
        .clk_i(clk_i), .rst_i(rst_i), .serial_clk_i(sclk), .chip_select_n_i(chip_select_n),
        .cmd_data_i(cdat), .tone_detect_i(tone_detect_i), .tone_code_i(tone_code_i),
        .reply_data_o(rdat), .reply_data_oe_n_o(rdat_oe_n), .interrupt_request_n_o(irq_n),
        .interrupt_request_oe_n_o(irq_oe_n), .ctrl_o(ctrl), .audio_o(audio),
        .tx_freq_o(txf), .clone_en_o(clone), .rx_slots_o(slots)
    );

    tcsp_host_model host (
        .serial_clk_o(sclk), .chip_select_n_o(chip_select_n), .cmd_data_o(cdat),
        .reply_data_i(rdat), .reply_data_oe_n_i(rdat_oe_n)
    );

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // ==========================================================
    // Shared helpers
    task automatic tally_and_finish();
        if (n_errors == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic wait_irq(input logic exp);
        for (int i = 0; i < 12 && irq_oe_n !== exp; i++) tick(1);
        check("irq_oe_n", 128'(irq_oe_n), 128'(exp));
        check("irq_n", 128'(irq_n), 128'(1'b0));
        if (irq_oe_n !== exp) tally_and_finish();
    endtask

    task automatic set_tone(input logic det, input logic [2:0] code);
        tick(1);
        tone_code_i = code;
        tone_detect_i = det;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        check("regs", 128'({ctrl, audio, txf, clone, slots}), 128'(ALL_RST));
        check("irq_oe_n", 128'(irq_oe_n), 128'(1'b1));
        check("reply_oe_n", 128'(rdat_oe_n), 128'(1'b1));
    endtask

    task automatic t_writes();
        host.xfer({tcsp_pkg::CMD_CTRL_WR, 8'hff, 8'h00}, 24, rx);
        host.xfer({tcsp_pkg::CMD_AUDIO_WR, 8'ha5, 8'h00}, 16, rx);
        host.xfer({tcsp_pkg::CMD_TXF_WR, 16'hffff}, 24, rx);
        host.xfer({tcsp_pkg::CMD_CLONE_WR, 8'h01, 8'h00}, 16, rx);
        host.xfer({8'h55, 16'hffff}, 24, rx);
        tick(4);
        check("ctrl", 128'(ctrl), 128'(8'hff & tcsp_pkg::CTRL_WR_MASK));
        check("audio", 128'(audio), 128'(8'ha5));
        check("txf", 128'(txf), 128'(16'hffff & tcsp_pkg::TXF_WR_MASK));
        check("clone", 128'(clone), 128'(1'b1));
    endtask

    task automatic t_slots();
        exp_s = '0;
        for (int k = 0; k < 7; k++) begin
            host.xfer({tcsp_pkg::CMD_RXPROG_WR, 1'b0, 3'(k), 12'(12'h5a0 + k)}, 24, rx);
            exp_s[12 * k +: 12] = 12'(12'h5a0 + k);
        end
        host.xfer({tcsp_pkg::CMD_RXPROG_WR, 1'b0, tcsp_pkg::SLOT_UNUSED, 12'hfff}, 24, rx);
        tick(4);
        check("slots", 128'(slots), 128'(exp_s));
    endtask

    task automatic t_abort();
        host.xfer({tcsp_pkg::CMD_AUDIO_WR, 8'hff, 8'h00}, 12, rx);
        tick(4);
        check("audio_abort", 128'(audio), 128'(8'ha5));
        host.xfer({tcsp_pkg::CMD_AUDIO_WR, 8'h00, 8'h00}, 4, rx);
        host.xfer({tcsp_pkg::CMD_AUDIO_WR, 8'h3c, 8'h00}, 16, rx);
        host.xfer({tcsp_pkg::CMD_TXF_WR, 8'h12, 8'h34}, 16, rx);
        tick(4);
        check("audio_after", 128'(audio), 128'(8'h3c));
        check("txf_partial", 128'(txf), 128'(16'hffff & tcsp_pkg::TXF_WR_MASK));
    endtask

    task automatic t_irq();
        host.xfer({tcsp_pkg::CMD_CTRL_WR, 8'h01, 8'h00}, 16, rx);
        set_tone(1'b1, 3'h5);
        wait_irq(1'b0);
        check("irq_line", 128'(irq_line), 128'(1'b0));
        host.xfer({tcsp_pkg::CMD_STAT_RD, 16'h0000}, 16, rx);
        check("status", 128'(rx), 128'({tcsp_pkg::STAT_PAD, 1'b1, 3'h5}));
        check("reply_oe_n", 128'(rdat_oe_n), 128'(1'b1));
        wait_irq(1'b1);
        set_tone(1'b0, 3'h2);
        wait_irq(1'b0);
        host.xfer({tcsp_pkg::CMD_GEN_RESET, 16'hffff}, 8, rx);
        wait_irq(1'b1);
        check("regs_reset", 128'({ctrl, audio, txf, clone, slots}), 128'(ALL_RST));
        host.xfer({tcsp_pkg::CMD_STAT_RD, 16'h0000}, 16, rx);
        check("status_kept", 128'(rx), 128'({tcsp_pkg::STAT_PAD, 1'b0, 3'h5}));
        host.xfer({tcsp_pkg::CMD_CTRL_WR, 8'h01, 8'h00}, 16, rx);
        set_tone(1'b1, 3'h3);
        wait_irq(1'b0);
        host.xfer({tcsp_pkg::CMD_CTRL_WR, 8'h00, 8'h00}, 16, rx);
        wait_irq(1'b1);
        set_tone(1'b0, 3'h3);
        tick(8);
        check("irq_masked", 128'(irq_oe_n), 128'(1'b1));
    endtask

    initial begin
        n_errors = 0;
        checks_done = 0;
        rst_i = 1'b1;
        tone_detect_i = 1'b0;
        tone_code_i = 3'h0;
        repeat (3) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        tick(3);
        t_reset();
        t_writes();
        t_slots();
        t_abort();
        t_irq();
        tally_and_finish();
    end
endmodule // tone_codec_host_serial_port_bench
